/* verilog/diag_pkg.sv */
// Package for the safety sensor diagnostic and status block.
// Assumes a single 20 MHz clock domain.
package diag_pkg;
    localparam int unsigned CLK_HZ           = 20000000;
    // Timing figures in their own units
    localparam int unsigned BLINK_HZ         = 1;
    localparam int unsigned WARN_MINUTES     = 30;
    localparam int unsigned PROT_MINUTES     = 10;
    localparam int unsigned FLASH_PULSE_MS   = 250;
    localparam int unsigned FLASH_PAUSE_MS   = 1500;
    // Cycle counts derived from the rate; every one divides out exactly
    localparam longint unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
    localparam longint unsigned WARN_CYC       = longint'(WARN_MINUTES) * 60 * CLK_HZ;
    localparam longint unsigned PROT_CYC       = longint'(PROT_MINUTES) * 60 * CLK_HZ;
    localparam longint unsigned FLASH_PULSE_CYC = longint'(FLASH_PULSE_MS) * CLK_HZ / 1000;
    localparam longint unsigned FLASH_PAUSE_CYC = longint'(FLASH_PAUSE_MS) * CLK_HZ / 1000;
    // Response byte bit positions
    localparam int unsigned RSP_OUT_EN  = 0;
    localparam int unsigned RSP_ACT     = 1;
    localparam int unsigned RSP_INPUTS  = 4;
    localparam int unsigned RSP_LIMIT   = 5;
    localparam int unsigned RSP_WARN    = 6;
    localparam int unsigned RSP_ERROR   = 7;
    // Request byte bit position
    localparam int unsigned REQ_RESET   = 7;
    // Flash code pulse counts
    localparam logic [2:0] CODE_NONE    = 3'h0;
    localparam logic [2:0] CODE_OUT_A   = 3'h1;
    localparam logic [2:0] CODE_OUT_B   = 3'h2;
    localparam logic [2:0] CODE_CROSS   = 3'h3;
    localparam logic [2:0] CODE_TEMP    = 3'h4;
    localparam logic [2:0] CODE_ACTR    = 3'h5;
    localparam logic [7:0] RSP_RESET    = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ACTIVE  = 3'b001,
        ST_WARN    = 3'b010,
        ST_ERROR   = 3'b011,
        ST_TEACH   = 3'b100,
        ST_PROTECT = 3'b101
    } state_t;
endpackage

/* verilog/blink_gen.sv */
// Free running square wave used for the 1 Hz lamp flashing.
// Assumes a single clock domain.
`timescale 1ns/1ns
`default_nettype none
module blink_gen #(
    parameter int unsigned HALF_CYC = 10000000
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    output logic      blink_o
);
    localparam int unsigned W = $clog2(HALF_CYC + 1);
    logic [W-1:0] cnt_q;
    wire          wrap = (cnt_q == W'(HALF_CYC - 1));

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q   <= '0;
            blink_o <= 1'b0;
        end else begin
            cnt_q   <= wrap ? '0 : cnt_q + W'(1);
            blink_o <= wrap ? ~blink_o : blink_o;
        end
    end
endmodule // blink_gen
`default_nettype wire

/* verilog/flash_code_gen.sv */
// Red lamp flash code: a group of N pulses, then a long pause, repeated.
// Assumes code_i is held steady while a fault stands.
`timescale 1ns/1ns
`default_nettype none
module flash_code_gen #(
    parameter int unsigned PULSE_CYC = 5000000,
    parameter int unsigned PAUSE_CYC = 30000000
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] code_i,
    output logic            flash_o
);
    localparam int unsigned W = $clog2(PAUSE_CYC + 1);
    logic [W-1:0] tmr_q;
    logic [3:0]   phase_q;
    // Pause is far longer than a pulse so groups stay countable
    wire in_pause  = (phase_q >= {code_i, 1'b0});
    wire tmr_end   = in_pause ? (tmr_q == W'(PAUSE_CYC - 1)) : (tmr_q == W'(PULSE_CYC - 1));
    wire idle      = (code_i == diag_pkg::CODE_NONE);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_q   <= '0;
            phase_q <= 4'h0;
            flash_o <= 1'b0;
        end else if (idle) begin
            tmr_q   <= '0;
            phase_q <= 4'h0;
            flash_o <= 1'b0;
        end else begin
            tmr_q   <= tmr_end ? '0 : tmr_q + W'(1);
            phase_q <= tmr_end ? (in_pause ? 4'h0 : phase_q + 4'h1) : phase_q;
            flash_o <= ~in_pause & ~phase_q[0];
        end
    end
endmodule // flash_code_gen
`default_nettype wire

/* verilog/sensor_diag.sv */
// Overview of operation
// - Green steady when ready, not warning/fault/teach/protect
// - Yellow steady while actuator in range
// - Limit area: yellow blinks 1 Hz, outputs on
// - Fault repeats red flash group, count gives cause
// - Red steady internal fault; with yellow flashing teach
// - Any fault drops diagnostic output at once
// - Uncleared warning drops safety outputs within 30 min
// - Limit area pulses diagnostic output like yellow
// - No actuator all low; actuated clean all high
// - Warning: green off, red flash, yellow on
// - Teach: green off, red on, yellow flashes, outputs low
// - Protection: green flashes, outputs low, 10 min pause
// - Publish response byte, accept request byte continuously
// - Communication loss keeps safety outputs unchanged
// - Response bits 0,1,4: outputs, actuator, inputs
// - Response bits 5,6,7: limit, warning, error
// - Error clears: cause gone and reset fall/guard open
// - Output faults clear only on next guard release
// - Warning clears itself when cause disappears
// - Status bit one means condition present
//
// Diagnostic and status logic of a non-contact safety sensor.
// Assumes the sensing front end supplies synchronous condition levels.
`timescale 1ns/1ns
`default_nettype none
module sensor_diag #(
    parameter longint unsigned WARN_CYC  = diag_pkg::WARN_CYC,
    parameter longint unsigned PROT_CYC  = diag_pkg::PROT_CYC,
    parameter int unsigned     BLINK_CYC = int'(diag_pkg::BLINK_HALF_CYC),
    parameter int unsigned     PULSE_CYC = int'(diag_pkg::FLASH_PULSE_CYC),
    parameter int unsigned     PAUSE_CYC = int'(diag_pkg::FLASH_PAUSE_CYC)
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ready_i,
    input  wire logic       actuated_i,
    input  wire logic       limit_area_i,
    input  wire logic       safety_in_a_i,
    input  wire logic       safety_in_b_i,
    input  wire logic       fault_out_a_i,
    input  wire logic       fault_out_b_i,
    input  wire logic       fault_cross_i,
    input  wire logic       fault_temp_i,
    input  wire logic       fault_actuator_i,
    input  wire logic       fault_internal_i,
    input  wire logic       warn_cause_i,
    input  wire logic       teach_i,
    input  wire logic       protect_start_i,
    input  wire logic       comm_ok_i,
    input  wire logic [7:0] request_i,
    output logic            led_green_o,
    output logic            led_yellow_o,
    output logic            led_red_o,
    output logic            diag_out_o,
    output logic            safety_out_a_o,
    output logic            safety_out_b_o,
    output logic [7:0]      response_o
);
    localparam int unsigned WW = $clog2(WARN_CYC + 1);
    localparam int unsigned PW = $clog2(PROT_CYC + 1);

    diag_pkg::state_t state_q;
    diag_pkg::state_t state_d;
    logic [WW-1:0]    warn_cnt_q;
    logic [PW-1:0]    prot_cnt_q;
    logic             req_bit_q;
    logic             out_err_q;
    logic             act_q;
    logic [2:0]       code_q;
    logic             blink;
    logic             flash;

    // Fault and reset decode
    wire out_fault   = fault_out_a_i | fault_out_b_i | fault_cross_i;
    wire any_fault   = out_fault | fault_temp_i | fault_actuator_i | fault_internal_i;
    // A dead link cannot deliver a reset request, so its stale byte is ignored
    wire req_fall    = req_bit_q & ~request_i[diag_pkg::REQ_RESET] & comm_ok_i;
    wire guard_open  = act_q & ~actuated_i;
    wire guard_rel   = ~act_q & actuated_i;
    // Output faults cannot be seen repaired before the guard moves again
    wire clr_ok      = (out_fault | out_err_q) ? guard_rel : (req_fall | guard_open);
    wire warn_expire = (warn_cnt_q == WW'(WARN_CYC - 1));
    wire prot_done   = (prot_cnt_q == PW'(PROT_CYC - 1));
    wire inputs_live = safety_in_a_i & safety_in_b_i;

    // Cause priority for the red flash group
    wire [2:0] code_d = fault_out_a_i    ? diag_pkg::CODE_OUT_A :
                        fault_out_b_i    ? diag_pkg::CODE_OUT_B :
                        fault_cross_i    ? diag_pkg::CODE_CROSS :
                        fault_temp_i     ? diag_pkg::CODE_TEMP  :
                        fault_actuator_i ? diag_pkg::CODE_ACTR  : code_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            diag_pkg::ST_IDLE: begin
                if (protect_start_i) state_d = diag_pkg::ST_PROTECT;
                else if (teach_i) state_d = diag_pkg::ST_TEACH;
                else if (any_fault) state_d = diag_pkg::ST_ERROR;
                else if (warn_cause_i && actuated_i) state_d = diag_pkg::ST_WARN;
                else if (actuated_i && inputs_live) state_d = diag_pkg::ST_ACTIVE;
            end
            diag_pkg::ST_ACTIVE: begin
                if (any_fault) state_d = diag_pkg::ST_ERROR;
                else if (warn_cause_i) state_d = diag_pkg::ST_WARN;
                else if (!actuated_i || !inputs_live) state_d = diag_pkg::ST_IDLE;
            end
            diag_pkg::ST_WARN: begin
                if (any_fault || warn_expire) state_d = diag_pkg::ST_ERROR;
                else if (!warn_cause_i) state_d = actuated_i ? diag_pkg::ST_ACTIVE : diag_pkg::ST_IDLE;
                else if (!actuated_i) state_d = diag_pkg::ST_IDLE;
            end
            diag_pkg::ST_ERROR: begin
                if (!any_fault && !warn_cause_i && clr_ok) state_d = diag_pkg::ST_IDLE;
            end
            diag_pkg::ST_TEACH: begin
                if (!teach_i) state_d = diag_pkg::ST_IDLE;
            end
            diag_pkg::ST_PROTECT: begin
                if (prot_done) state_d = diag_pkg::ST_IDLE;
            end
            default: state_d = diag_pkg::ST_IDLE;
        endcase
    end

    wire st_idle   = (state_q == diag_pkg::ST_IDLE);
    wire st_active = (state_q == diag_pkg::ST_ACTIVE);
    wire st_warn   = (state_q == diag_pkg::ST_WARN);
    wire st_error  = (state_q == diag_pkg::ST_ERROR);
    wire st_teach  = (state_q == diag_pkg::ST_TEACH);
    wire st_prot   = (state_q == diag_pkg::ST_PROTECT);
    wire err_next  = (state_d == diag_pkg::ST_ERROR);

    // Lamp and output decode
    wire green_d  = st_prot ? blink : ((st_idle | st_active) & ready_i);
    wire yellow_d = st_teach ? blink : (st_prot ? 1'b0 :
                    (actuated_i & ((st_active & limit_area_i) ? blink : 1'b1)));
    wire internal = fault_internal_i & (code_d == diag_pkg::CODE_NONE);
    // Warnings carry no pulse code, so they flash at the lamp rate
    wire red_flash = (code_q == diag_pkg::CODE_NONE) ? blink : flash;
    wire red_d    = st_teach | ((st_error | st_warn) & (internal ? 1'b1 : red_flash));
    // Diagnostic output falls with the fault, safety outputs one cycle later in the error state
    wire diag_d   = st_active & ~any_fault & (limit_area_i ? blink : 1'b1);
    wire safe_en  = st_active | st_warn;
    // A lost link changes nothing here: outputs follow local state only
    wire safe_d   = safe_en;

    wire [7:0] rsp_d = {st_error,
                        st_warn | st_error,
                        st_active & limit_area_i,
                        inputs_live,
                        2'b00,
                        actuated_i & ~fault_actuator_i,
                        safe_d};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= diag_pkg::ST_IDLE;
            warn_cnt_q <= '0;
            prot_cnt_q <= '0;
            req_bit_q  <= 1'b0;
            out_err_q  <= 1'b0;
            act_q      <= 1'b0;
            code_q     <= diag_pkg::CODE_NONE;
        end else begin
            state_q    <= state_d;
            warn_cnt_q <= st_warn ? warn_cnt_q + WW'(1) : '0;
            prot_cnt_q <= st_prot ? prot_cnt_q + PW'(1) : '0;
            req_bit_q  <= request_i[diag_pkg::REQ_RESET];
            out_err_q  <= err_next & (out_err_q | out_fault);
            act_q      <= actuated_i;
            code_q     <= st_error | st_warn ? code_d : diag_pkg::CODE_NONE;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            led_green_o    <= 1'b0;
            led_yellow_o   <= 1'b0;
            led_red_o      <= 1'b0;
            diag_out_o     <= 1'b0;
            safety_out_a_o <= 1'b0;
            safety_out_b_o <= 1'b0;
            response_o     <= diag_pkg::RSP_RESET;
        end else begin
            led_green_o    <= green_d;
            led_yellow_o   <= yellow_d;
            led_red_o      <= red_d;
            diag_out_o     <= diag_d;
            safety_out_a_o <= safe_d;
            safety_out_b_o <= safe_d;
            response_o     <= rsp_d;
        end
    end

    blink_gen #(
        .HALF_CYC (BLINK_CYC)
    ) u_blink (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .blink_o (blink)
    );

    flash_code_gen #(
        .PULSE_CYC (PULSE_CYC),
        .PAUSE_CYC (PAUSE_CYC)
    ) u_flash (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .code_i  (code_q),
        .flash_o (flash)
    );
endmodule // sensor_diag
`default_nettype wire

/* tb/sensor_diag_checker.sv */
// Port-level assertions for the sensor diagnostic block.
// Assumes one clock, bound onto the block by the testbench.
`timescale 1ns/1ns
`default_nettype none
module sensor_diag_checker #(
    parameter longint unsigned WARN_CYC = 100
) (
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       teach_i,
    input wire logic       fault_temp_i,
    input wire logic       led_green_o,
    input wire logic       led_red_o,
    input wire logic       diag_out_o,
    input wire logic       safety_out_a_o,
    input wire logic       safety_out_b_o,
    input wire logic [7:0] response_o
);
    // Margin covers the two-register output path
    localparam int W_MAX = int'(WARN_CYC) + 6;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_pair; safety_out_a_o == safety_out_b_o; endproperty
    a_pair: assert property (p_pair) else $error("safety outputs differ");
    property p_spare; response_o[3:2] == 2'b00; endproperty
    a_spare: assert property (p_spare) else $error("spare response bits set");
    property p_out_bit; response_o[0] == safety_out_a_o; endproperty
    a_out_bit: assert property (p_out_bit) else $error("bit 0 disagrees with outputs");
    property p_err_off; response_o[7] |-> !safety_out_a_o && !led_green_o; endproperty
    a_err_off: assert property (p_err_off) else $error("error with outputs on");
    property p_warn; response_o[6] && !response_o[7] |-> !diag_out_o && !led_green_o && safety_out_a_o; endproperty
    a_warn: assert property (p_warn) else $error("warning outputs wrong");
    property p_fault_diag; fault_temp_i [*3] |-> !diag_out_o; endproperty
    a_fault_diag: assert property (p_fault_diag) else $error("diag high in fault");
    // Red without warning or error bits can only come from the teach state
    property p_teach; teach_i && led_red_o && !response_o[6] |-> !safety_out_a_o && !diag_out_o && !led_green_o;
    endproperty
    a_teach: assert property (p_teach) else $error("teach outputs wrong");
    property p_warn_limit; $rose(response_o[6]) |-> ##[1:W_MAX] (!response_o[6] || response_o[7]); endproperty
    a_warn_limit: assert property (p_warn_limit) else $error("warning outlived timeout");
    property p_limit_on; response_o[5] |-> safety_out_a_o; endproperty
    a_limit_on: assert property (p_limit_on) else $error("limit area with outputs off");
endmodule // sensor_diag_checker
`default_nettype wire

/* tb/gateway_model.sv */
// Serial diagnostic gateway stand-in: reads response bytes, sends request bytes.
// Assumes the clock of the sensor block.
`timescale 1ns/1ns
`default_nettype none
module gateway_model #(
    parameter int unsigned CHAIN_LEN = 1 // No more than 31 sensors per chain
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       reset_cmd_i,
    input  wire logic       link_up_i,
    input  wire logic [6:0] spare_i,
    input  wire logic [7:0] response_i,
    output logic [7:0]      request_o,
    output logic            comm_ok_o,
    output logic [7:0]      seen_o
);
    logic [1:0] seq_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_q <= 2'h0;
            seen_o <= 8'h00;
        end else begin
            seq_q <= {seq_q[0], reset_cmd_i};
            seen_o <= response_i;
        end
    end
    // Reset acts on the fall, so bit 7 is held high two cycles first
    assign request_o = {seq_q[0] | seq_q[1], spare_i};
    assign comm_ok_o = link_up_i;
endmodule // gateway_model
`default_nettype wire

/* tb/safety_sensor_diagnostic_status_test.sv */
// Self-checking testbench of the sensor diagnostic block.
// Assumes short timing parameters in place of minutes.
`timescale 1ns/1ns
`default_nettype none
module safety_sensor_diagnostic_status_test;
    localparam int W = 100;
    localparam int P = 50;
    localparam int PA = 20;
    logic       mclk_i = 0, rst_n_i = 0, ready_i = 0, actuated_i = 0, limit_area_i = 0;
    logic       in_a = 0, in_b = 0, warn_cause_i = 0, teach_i = 0, protect_start_i = 0;
    logic       rcmd = 0, link = 1, comm_ok_i, g, y, r, d, sa, sb;
    logic [5:0] flt = 0;
    logic [6:0] spare = 0;
    logic [7:0] request_i, response_o, seen;
    int         n_fail = 0, n_checks = 0;
    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) spare <= 7'($urandom);
    gateway_model i_gw (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reset_cmd_i(rcmd), .link_up_i(link),
        .spare_i(spare), .response_i(response_o), .request_o(request_i), .comm_ok_o(comm_ok_i), .seen_o(seen));
    sensor_diag #(.WARN_CYC(W), .PROT_CYC(P), .BLINK_CYC(4), .PULSE_CYC(3), .PAUSE_CYC(PA)) i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ready_i(ready_i), .actuated_i(actuated_i),
        .limit_area_i(limit_area_i), .safety_in_a_i(in_a), .safety_in_b_i(in_b), .fault_out_a_i(flt[0]),
        .fault_out_b_i(flt[1]), .fault_cross_i(flt[2]), .fault_temp_i(flt[3]), .fault_actuator_i(flt[4]),
        .fault_internal_i(flt[5]), .warn_cause_i(warn_cause_i), .teach_i(teach_i),
        .protect_start_i(protect_start_i), .comm_ok_i(comm_ok_i), .request_i(request_i), .led_green_o(g),
        .led_yellow_o(y), .led_red_o(r), .diag_out_o(d), .safety_out_a_o(sa), .safety_out_b_o(sb),
        .response_o(response_o));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Modes: 0 idle, 1 actuated, 2 limit, 3 warning, 4 error, 5 teach, 6 protection
    task automatic look(input int m);
        logic s;
        logic [7:0] e;
        step(6);
        @(negedge mclk_i);
        s = (m >= 1 && m <= 3);
        e = {m == 4, m == 3 || m == 4, m == 2, in_a & in_b, 2'b00, (m >= 1 && m <= 4) && actuated_i && !flt[4], s};
        chk("response", e, response_o);
        chk("gateway copy", e, seen);
        chk("safety", {7'h0, s}, {7'h0, sb});
        if (m != 2)
            chk("diag", {7'h0, m == 1}, {7'h0, d});
        if (m != 6)
            chk("green", {7'h0, m <= 2}, {7'h0, g});
    endtask
    // want: bit 1 high seen, bit 0 low seen
    task automatic lvl(input string what, input int sel, input int win, input logic [1:0] want);
        logic v;
        logic [1:0] seen;
        seen = 2'b00;
        repeat (win) begin
            @(negedge mclk_i);
            v = sel == 0 ? y : sel == 1 ? d : sel == 2 ? r : g;
            seen = seen | {v === 1'b1, v === 1'b0};
        end
        chk(what, {6'h0, want}, {6'h0, seen});
    endtask
    // Counts red pulses between two pauses
    task automatic pulses(input logic [7:0] n);
        int quiet, rises;
        logic prev, armed;
        quiet = 0; rises = 0; prev = 0; armed = 0;
        repeat (400) begin
            @(negedge mclk_i);
            if (r === 1'b1) begin
                if (!prev && armed) rises++;
                quiet = 0;
            end else quiet++;
            prev = r;
            if (quiet == PA - 2) begin
                if (armed && rises > 0) break;
                armed = 1;
            end
        end
        chk("flash count", n, 8'(rises));
    endtask
    initial begin
        spare = 7'($urandom(32'ha0ae3516));
        step(20);
        rst_n_i <= 1; ready_i <= 1; in_a <= 1; in_b <= 1;
        look(0);
        step(1); actuated_i <= 1;
        look(1);
        step(1); limit_area_i <= 1;
        look(2);
        lvl("yellow blink", 0, 20, 2'b11);
        lvl("diag pulse", 1, 20, 2'b11);
        step(1); limit_area_i <= 0; warn_cause_i <= 1; link <= 0;
        look(3);
        lvl("red flash", 2, 60, 2'b11);
        step(1); warn_cause_i <= 0; link <= 1;
        look(1);
        step(1); warn_cause_i <= 1;
        step(W);
        look(4);
        step(1); warn_cause_i <= 0;
        look(4);
        step(1); rcmd <= 1; step(1); rcmd <= 0;
        look(1);
        for (int i = 0; i < 5; i++) begin
            step(1); flt[i] <= 1;
            look(4);
            pulses(8'(i + 1));
            step(1); flt[i] <= 0; rcmd <= 1;
            step(1); rcmd <= 0;
            look(i < 3 ? 4 : 1);
            if (i < 3) begin
                step(1); actuated_i <= 0;
                step(2); actuated_i <= 1;
                look(1);
            end
        end
        step(1); flt[5] <= 1;
        look(4);
        lvl("red steady", 2, 40, 2'b10);
        step(1); flt[5] <= 0; rcmd <= 1; step(1); rcmd <= 0;
        look(1);
        step(1); actuated_i <= 0; teach_i <= 1;
        look(5);
        lvl("teach red", 2, 20, 2'b10);
        lvl("teach yellow", 0, 20, 2'b11);
        step(1); teach_i <= 0;
        look(0);
        step(1); protect_start_i <= 1; step(1); protect_start_i <= 0;
        look(6);
        lvl("protect green", 3, 16, 2'b11);
        lvl("protect red", 2, 8, 2'b01);
        step(P);
        look(0);
        give_verdict();
    end
    initial begin
        step(8000);
        n_fail++;
        give_verdict();
    end
endmodule // safety_sensor_diagnostic_status_test
bind sensor_diag sensor_diag_checker #(.WARN_CYC(WARN_CYC)) i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .teach_i(teach_i), .fault_temp_i(fault_temp_i), .led_green_o(led_green_o), .led_red_o(led_red_o),
    .diag_out_o(diag_out_o),
    .safety_out_a_o(safety_out_a_o), .safety_out_b_o(safety_out_b_o), .response_o(response_o));
`default_nettype wire
